/* src/acg_config_regs.v */
// Clock and gain configuration registers of the converter, APB slave
//
// The implementer's own choice: the APB slave port.
`include "acg_defines.vh"

// Registered power-of-two decode shared by ratio and gain outputs
module acg_pow2_decode
#(
   parameter CODE_WIDTH = 3,
   parameter VALUE_WIDTH = 8,
   parameter [VALUE_WIDTH-1:0] BASE_VALUE = 8'h01,
   parameter [CODE_WIDTH-1:0] RESET_CODE = 3'h0
)
(
   input wire pclk,
   input wire presetn,
   input wire [CODE_WIDTH-1:0] code_next,
   output reg [CODE_WIDTH-1:0] code_reg,
   output reg [VALUE_WIDTH-1:0] value_reg
);

   // Reset value is a constant so the reset branch stays free of logic
   localparam [VALUE_WIDTH-1:0] RESET_VALUE = BASE_VALUE << RESET_CODE;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         code_reg <= RESET_CODE;
      end
      else
      begin
         code_reg <= code_next;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         value_reg <= RESET_VALUE;
      end
      else
      begin
         value_reg <= BASE_VALUE << code_next;
      end
   end

endmodule // acg_pow2_decode

module acg_config_regs
#(
   parameter ADDR_WIDTH = 12,
   parameter DATA_WIDTH = 32
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_WIDTH-1:0] paddr,
   input wire [DATA_WIDTH-1:0] pwdata,
   input wire [DATA_WIDTH/8-1:0] pstrb,
   output reg [DATA_WIDTH-1:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg second_channel_enable,
   output reg first_channel_enable,
   output reg ext_clock_select,
   output wire [2:0] oversampling_ratio_code,
   output wire [14:0] oversampling_ratio,
   output reg [1:0] power_mode_code,
   output reg [1:0] power_mode,
   output wire [2:0] second_channel_gain_code,
   output wire [7:0] second_channel_gain,
   output wire [2:0] first_channel_gain_code,
   output wire [7:0] first_channel_gain
);

   localparam [15:0] CLOCK_RESET = `ACG_CLOCK_RESET;
   localparam [15:0] GAIN_RESET = `ACG_GAIN_RESET;
   localparam [ADDR_WIDTH-1:0] CLOCK_ADDR = `ACG_CLOCK_ADDR;
   localparam [ADDR_WIDTH-1:0] GAIN_ADDR = `ACG_GAIN_ADDR;
   localparam [DATA_WIDTH-17:0] UPPER_ZERO = {(DATA_WIDTH-16){1'b0}};

   reg [15:0] clock_channel_config_reg;
   reg [15:0] gain_config_reg;
   reg [15:0] clock_channel_config_next;
   reg [15:0] gain_config_next;
   reg [DATA_WIDTH-1:0] prdata_next;
   reg [1:0] power_mode_next;
   reg hit_clock;
   reg hit_gain;
   reg hit_any;
   reg access;
   reg write_access;
   reg read_access;

   // Access cycle answers ready one cycle later, so each transfer takes three cycles
   always @*
   begin
      access = psel & penable & ~pready;
      write_access = access & pwrite;
      read_access = access & ~pwrite;
      hit_clock = (paddr == CLOCK_ADDR);
      hit_gain = (paddr == GAIN_ADDR);
      hit_any = hit_clock | hit_gain;
   end

   always @*
   begin
      clock_channel_config_next = clock_channel_config_reg;
      if (write_access && hit_clock)
      begin
         if (pstrb[0])
         begin
            clock_channel_config_next[7:0] = pwdata[7:0];
         end
         if (pstrb[1])
         begin
            clock_channel_config_next[9:8] = pwdata[9:8];
         end
      end
      // Read-only top bits never take a write
      clock_channel_config_next[`ACG_CLOCK_RO_HI:`ACG_CLOCK_RO_LO] = 6'h00;
   end

   // Reserved bits are stored as written; keeping them zero is the writer's duty
   always @*
   begin
      gain_config_next = gain_config_reg;
      if (write_access && hit_gain)
      begin
         if (pstrb[0])
         begin
            gain_config_next[7:0] = pwdata[7:0];
         end
         if (pstrb[1])
         begin
            gain_config_next[15:8] = pwdata[15:8];
         end
      end
   end

   always @*
   begin
      if (hit_clock)
      begin
         prdata_next = {UPPER_ZERO, clock_channel_config_reg};
      end
      else if (hit_gain)
      begin
         prdata_next = {UPPER_ZERO, gain_config_reg};
      end
      else
      begin
         prdata_next = {DATA_WIDTH{1'b0}};
      end
   end

   always @*
   begin
      if (clock_channel_config_next[`ACG_PWR_HI:`ACG_PWR_LO] == `ACG_PWR_HIGH_RES_ALT)
      begin
         power_mode_next = `ACG_PWR_HIGH_RES;
      end
      else
      begin
         power_mode_next = clock_channel_config_next[`ACG_PWR_HI:`ACG_PWR_LO];
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clock_channel_config_reg <= CLOCK_RESET;
      end
      else
      begin
         clock_channel_config_reg <= clock_channel_config_next;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gain_config_reg <= GAIN_RESET;
      end
      else
      begin
         gain_config_reg <= gain_config_next;
      end
   end

   // Ready is a one-cycle pulse; the guard on ready stops a second acceptance
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= access;
         pslverr <= access & ~hit_any;
      end
   end

   // Read data is zero outside the answer cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= {DATA_WIDTH{1'b0}};
      end
      else if (read_access)
      begin
         prdata <= prdata_next;
      end
      else
      begin
         prdata <= {DATA_WIDTH{1'b0}};
      end
   end

   // Decoded controls are registered so the fan-out sees clean flops
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         second_channel_enable <= CLOCK_RESET[`ACG_SECOND_CHANNEL_ENABLE_BIT];
         first_channel_enable <= CLOCK_RESET[`ACG_FIRST_CHANNEL_ENABLE_BIT];
         ext_clock_select <= CLOCK_RESET[`ACG_CLK_SEL_BIT];
      end
      else
      begin
         second_channel_enable <= clock_channel_config_next[`ACG_SECOND_CHANNEL_ENABLE_BIT];
         first_channel_enable <= clock_channel_config_next[`ACG_FIRST_CHANNEL_ENABLE_BIT];
         ext_clock_select <= clock_channel_config_next[`ACG_CLK_SEL_BIT];
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         power_mode_code <= CLOCK_RESET[`ACG_PWR_HI:`ACG_PWR_LO];
         power_mode <= CLOCK_RESET[`ACG_PWR_HI:`ACG_PWR_LO];
      end
      else
      begin
         power_mode_code <= clock_channel_config_next[`ACG_PWR_HI:`ACG_PWR_LO];
         power_mode <= power_mode_next;
      end
   end

   // Ratio is 128 shifted by the code, so 16384 still fits in 15 bits
   acg_pow2_decode
   #(
      .CODE_WIDTH(3),
      .VALUE_WIDTH(15),
      .BASE_VALUE(`ACG_OSR_BASE),
      .RESET_CODE(CLOCK_RESET[`ACG_OSR_HI:`ACG_OSR_LO])
   )
   osr_decode_inst
   (
      .pclk(pclk),
      .presetn(presetn),
      .code_next(clock_channel_config_next[`ACG_OSR_HI:`ACG_OSR_LO]),
      .code_reg(oversampling_ratio_code),
      .value_reg(oversampling_ratio)
   );

   acg_pow2_decode
   #(
      .CODE_WIDTH(3),
      .VALUE_WIDTH(8),
      .BASE_VALUE(8'h01),
      .RESET_CODE(GAIN_RESET[`ACG_GAIN1_HI:`ACG_GAIN1_LO])
   )
   gain1_decode_inst
   (
      .pclk(pclk),
      .presetn(presetn),
      .code_next(gain_config_next[`ACG_GAIN1_HI:`ACG_GAIN1_LO]),
      .code_reg(second_channel_gain_code),
      .value_reg(second_channel_gain)
   );

   acg_pow2_decode
   #(
      .CODE_WIDTH(3),
      .VALUE_WIDTH(8),
      .BASE_VALUE(8'h01),
      .RESET_CODE(GAIN_RESET[`ACG_GAIN0_HI:`ACG_GAIN0_LO])
   )
   gain0_decode_inst
   (
      .pclk(pclk),
      .presetn(presetn),
      .code_next(gain_config_next[`ACG_GAIN0_HI:`ACG_GAIN0_LO]),
      .code_reg(first_channel_gain_code),
      .value_reg(first_channel_gain)
   );

endmodule // acg_config_regs

/* src/acg_defines.vh */
// Register offsets, field positions and reset values of the configuration bank
`ifndef ACG_DEFINES_VH
`define ACG_DEFINES_VH
`define ACG_CLOCK_IDX 8'h03
`define ACG_GAIN_IDX 8'h04
`define ACG_CLOCK_ADDR 12'h00c
`define ACG_GAIN_ADDR 12'h010
`define ACG_CLOCK_RESET 16'h038e
`define ACG_GAIN_RESET 16'h0000
`define ACG_SECOND_CHANNEL_ENABLE_BIT 9
`define ACG_FIRST_CHANNEL_ENABLE_BIT 8
`define ACG_CLK_SEL_BIT 7
`define ACG_CLOCK_RO_HI 15
`define ACG_CLOCK_RO_LO 10
`define ACG_CLOCK_RSV_HI 6
`define ACG_CLOCK_RSV_LO 5
`define ACG_OSR_HI 4
`define ACG_OSR_LO 2
`define ACG_PWR_HI 1
`define ACG_PWR_LO 0
`define ACG_GAIN1_HI 6
`define ACG_GAIN1_LO 4
`define ACG_GAIN0_HI 2
`define ACG_GAIN0_LO 0
`define ACG_GAIN_RSV_BIT 3
`define ACG_GAIN_RSV_HI 15
`define ACG_GAIN_RSV_LO 7
`define ACG_OSR_BASE 15'h0080
`define ACG_PWR_VERY_LOW 2'h0
`define ACG_PWR_LOW 2'h1
`define ACG_PWR_HIGH_RES 2'h2
`define ACG_PWR_HIGH_RES_ALT 2'h3
`endif

/* tb/acg_config_regs_bench.sv */
// Self-checking bench for the configuration bank
module acg_config_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [3:0] pstrb = 4'hf;
   logic second_channel_enable, first_channel_enable, ext_clock_select;
   logic [2:0] oversampling_ratio_code, second_channel_gain_code, first_channel_gain_code;
   logic [14:0] oversampling_ratio;
   logic [1:0] power_mode_code, power_mode;
   logic [7:0] second_channel_gain, first_channel_gain;
   int bad_count = 0, comparisons = 0;
   acg_config_regs acg_config_regs_inst (.*);
   always #10 pclk = ~pclk;
   task summarize;
      $display("%0d compared, %0d wrong", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
         @(posedge pclk);
      while (pready !== 1 && ++n < 20);
      bad_count += n == 20;
      if (n == 20)
         summarize;
      r = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task t_reset;
      apb(0, 12'h00c, 0);
      chk(r, 32'h038e);
      apb(0, 12'h010, 0);
      chk(r, 0);
      chk({second_channel_enable, first_channel_enable, ext_clock_select}, 3'h7);
      chk({oversampling_ratio, power_mode}, {15'd1024, 2'h2});
      chk({oversampling_ratio_code, power_mode_code}, {3'h3, 2'h2});
      chk({second_channel_gain_code, first_channel_gain_code}, 6'h00);
      chk({second_channel_gain, first_channel_gain}, 16'h0101);
      $display("reset test done");
   endtask
   task t_clock;
      for (int i = 0; i < 8; i++)
      begin
         apb(1, 12'h00c, {i[1], i[0], i[0], 2'h0, i[2:0], i[1:0]});
         chk({second_channel_enable, first_channel_enable, ext_clock_select, oversampling_ratio},
            {i[1], i[0], i[0], 15'h0080 << i});
         chk(power_mode, i[1:0] == 3 ? 2 : i[1:0]);
         chk({oversampling_ratio_code, power_mode_code}, {i[2:0], i[1:0]});
      end
      apb(1, 12'h00c, 32'h0000ff9f);
      apb(0, 12'h00c, 0);
      chk(r, 32'h039f);
      $display("clock test done");
   endtask
   task t_gain;
      for (int i = 0; i < 8; i++)
      begin
         apb(1, 12'h010, {i[2:0], 1'b0, ~i[2:0]});
         chk({second_channel_gain, first_channel_gain}, {8'h01 << i, 8'h80 >> i});
         chk({second_channel_gain_code, first_channel_gain_code}, {i[2:0], ~i[2:0]});
      end
      $display("gain test done");
   endtask
   task t_strobe;
      pstrb <= 4'h1;
      apb(1, 12'h00c, 0);
      chk({second_channel_enable, first_channel_enable, ext_clock_select}, 3'h6);
      pstrb <= 4'h2;
      apb(1, 12'h00c, 0);
      pstrb <= 4'hf;
      apb(0, 12'h00c, 0);
      chk(r, 32'h0000);
      $display("strobe test done");
   endtask
   task t_bad;
      apb(1, 12'h020, 32'h0077);
      apb(0, 12'h020, 0);
      chk({er, r[30:0]}, 32'h80000000);
      apb(0, 12'h010, 0);
      chk(r, 32'h0070);
      $display("unmapped test done");
   endtask
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_reset;
      t_clock;
      t_strobe;
      t_gain;
      t_bad;
      summarize;
   end
endmodule // acg_config_regs_bench

/* tb/acg_config_regs_monitor.sv */
// Assertions on the configuration bank ports
module acg_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [3:0] pstrb,
   input wire logic [2:0] oversampling_ratio_code,
   input wire logic [14:0] oversampling_ratio,
   input wire logic [1:0] power_mode_code,
   input wire logic [1:0] power_mode,
   input wire logic ext_clock_select,
   input wire logic second_channel_enable,
   input wire logic first_channel_enable,
   input wire logic [2:0] second_channel_gain_code,
   input wire logic [7:0] second_channel_gain,
   input wire logic [2:0] first_channel_gain_code,
   input wire logic [7:0] first_channel_gain
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_s; psel && penable && !pready; endsequence
   sequence wclk_s; acc_s ##0 pwrite && paddr == 12'h00c; endsequence
   access_ready_a: assert property (acc_s |=> pready) else $error("no ready");
   chan_enable_a: assert property (wclk_s ##0 pstrb[1] |=>
      {second_channel_enable, first_channel_enable} == $past(pwdata[9:8])) else $error("enable");
   clock_source_a: assert property (wclk_s ##0 pstrb[0] |=>
      ext_clock_select == $past(pwdata[7])) else $error("clock source");
   osr_value_a: assert property (wclk_s ##0 pstrb[0] |=>
      oversampling_ratio == 15'h0080 << $past(pwdata[4:2])) else $error("ratio");
   power_map_a: assert property (
      power_mode == (&power_mode_code ? 2'h2 : power_mode_code)) else $error("power mode");
   gain_value_a: assert property (
      second_channel_gain == 8'h01 << second_channel_gain_code) else $error("gain");
   first_gain_a: assert property (
      first_channel_gain == 8'h01 << first_channel_gain_code) else $error("first gain");
   osr_code_a: assert property (wclk_s ##0 pstrb[0] |=>
      oversampling_ratio_code == $past(pwdata[4:2])) else $error("ratio code");
   reserved_zero_a: assert property (
      pready && !pwrite && paddr == 12'h00c |-> prdata[31:10] == 0) else $error("reserved");
   unmapped_read_a: assert property (
      pready && paddr != 12'h00c && paddr != 12'h010 |-> pslverr && prdata == 0)
      else $error("unmapped");
endmodule // acg_monitor
bind acg_config_regs acg_monitor acg_monitor_inst (.*);
